//--- tb/rltco_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module rltco_pins_model (
    input wire logic ref_clk_i,
    input wire logic pin_oe_i,
    input wire logic pin_drv_i,
    output logic count_pin_o,
    output logic dir_pin_o
);
    logic cnt_lvl_q;
    // design output wins the pin while it drives it
    assign count_pin_o = pin_oe_i ? pin_drv_i : cnt_lvl_q;
    initial begin
        cnt_lvl_q = 1'b1;
        dir_pin_o = 1'b1;
    end
    // slow edges so the two-flop sync never misses one
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            cnt_lvl_q <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            cnt_lvl_q <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask
    task automatic set_dir(input logic lvl);
        @(posedge ref_clk_i);
        dir_pin_o <= lvl;
        repeat (6) @(posedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_reload_timer_with_clock_out.sv
`timescale 1ns/1ns
`default_nettype none
module tb_reload_timer_with_clock_out;
    logic ref_clk, arst_n, wr_s, rd_s, pin_o, pin_oe, dir, cnt_pin, irq, baud;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [15:0] r;
    int fails = 0, checked = 0, cyc = 0, n, k, h, mdl[8];
    rltco_top dut_u (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .count_clock_pin_i(cnt_pin),
        .count_clock_pin_o(pin_o), .count_clock_pin_oe_o(pin_oe),
        .direction_trigger_input_i(dir), .irq_o(irq), .baud_tick_o(baud));
    rltco_pins_model pins_u (.ref_clk_i(ref_clk), .pin_oe_i(pin_oe),
        .pin_drv_i(pin_o), .count_pin_o(cnt_pin), .dir_pin_o(dir));
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] mw(input int a);
        return 16'(mdl[a + 1] * 256 + mdl[a]);
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
        wdata <= 8'($urandom);
        if (a == 3'h1) mdl[a] = v & 8'h03;
        else if (a < 3'h6) mdl[a] = v;
    endtask
    task automatic wr16(input logic [2:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 3'h1, v[15:8]);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        addr <= 3'($urandom);
        #1 v = rdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        logic [7:0] v;
        rd(a, v);
        check({8'h00, v}, e);
    endtask
    task automatic rdw(input logic [2:0] a, input logic [15:0] e);
        logic [7:0] lo, hi;
        rd(a, lo);
        rd(a + 3'h1, hi);
        check({hi, lo}, e);
    endtask
    task automatic irqc(input logic e);
        repeat (2) @(posedge ref_clk);
        check({15'h0000, irq}, {15'h0000, e});
    endtask
    // sampled per edge, so a one-cycle glitch still shows
    task automatic rise_wait(output int c);
        logic p;
        c = 0;
        do begin
            p = pin_o;
            @(negedge ref_clk);
            c++;
        end while (!(p === 1'b0 && pin_o === 1'b1) && c < 200);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            complete_run();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        r = 16'($urandom(32'he32e));
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rdc(3'(a), 16'h0000);
        for (int a = 1; a < 8; a++) begin
            wr(3'(a), 8'($urandom));
            rdc(3'(a), mdl[a][15:0]);
        end
        wr(3'h1, 8'h00);
        wr16(3'h4, 16'h1234);
        wr16(3'h2, 16'hFFFE);
        wr(3'h0, 8'h06);
        pins_u.pulse_count(3);
        rdw(3'h2, mw(4) + 16'h0001);
        rdc(3'h0, 16'h0086);
        irqc(1'b1);
        wr(3'h0, 8'h02);
        pins_u.pulse_count(2);
        rdw(3'h2, mw(4) + 16'h0001);
        irqc(1'b0);
        wr(3'h1, 8'h01);
        wr16(3'h4, 16'h1230);
        wr16(3'h2, 16'h1232);
        pins_u.set_dir(1'b0);
        wr(3'h0, 8'h06);
        pins_u.pulse_count(3);
        rdw(3'h2, 16'hFFFF);
        rdc(3'h0, 16'h00C6);
        wr(3'h0, 8'h46);
        irqc(1'b0);
        pins_u.set_dir(1'b1);
        pins_u.pulse_count(1);
        rdw(3'h2, mw(4));
        rdc(3'h0, 16'h0086);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h00);
        wr16(3'h2, r);
        wr(3'h0, 8'h0F);
        pins_u.set_dir(1'b0);
        rdw(3'h4, r);
        rdc(3'h0, 16'h004F);
        irqc(1'b1);
        pins_u.set_dir(1'b1);
        wr(3'h0, 8'h0E);
        wr16(3'h2, 16'h0000);
        pins_u.set_dir(1'b0);
        rdw(3'h2, r);
        rdc(3'h0, 16'h004E);
        wr(3'h0, 8'h00);
        wr16(3'h2, 16'h0000);
        wr(3'h0, 8'h04);
        repeat (120) @(posedge ref_clk);
        wr(3'h0, 8'h00);
        rd(3'h2, d);
        check(16'(d >= 8'h09 && d <= 8'h0B), 16'h0001);
        // setup order matters: enable, source, reload, count, run
        wr(3'h1, 8'h02);
        wr(3'h0, 8'h10);
        wr16(3'h4, 16'hFFFC);
        wr16(3'h2, 16'hFFFC);
        wr(3'h0, 8'h14);
        check(16'(pin_oe), 16'h0001);
        rise_wait(n);
        rise_wait(n);
        check(16'(n), 16'(4 * (65536 - mw(4))));
        k = 0;
        h = 0;
        repeat (64) begin
            @(negedge ref_clk);
            if (baud === 1'b1) k++;
            if (pin_o === 1'b1) h++;
        end
        check(16'(k), 16'(64 / (2 * (65536 - mw(4)))));
        check(16'(h), 16'h0020);
        rdc(3'h0, 16'h0014);
        irqc(1'b0);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire

//--- verilog/rltco_cfg.svh
`ifndef RLTCO_CFG_SVH
`define RLTCO_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RLTCO_OFS_CTRL 3'h0
`define RLTCO_OFS_MODE 3'h1
`define RLTCO_OFS_CNTL 3'h2
`define RLTCO_OFS_CNTH 3'h3
`define RLTCO_OFS_RELL 3'h4
`define RLTCO_OFS_RELH 3'h5
// ----------------------------------------
// control bits
// ----------------------------------------
`define RLTCO_B_OVF 7
`define RLTCO_B_EXF 6
`define RLTCO_B_RXS 5
`define RLTCO_B_TXS 4
`define RLTCO_B_EXEN 3
`define RLTCO_B_RUN 2
`define RLTCO_B_CNT 1
`define RLTCO_B_CAP 0
`define RLTCO_B_OE 1
`define RLTCO_B_UDEN 0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RLTCO_CTRL_RST 8'h00
`define RLTCO_MODE_RST 2'h0
`define RLTCO_WORD_RST 16'h0000
`define RLTCO_WORD_TOP 16'hFFFF
`define RLTCO_OSC_DIV 12
`endif

//--- verilog/rltco_pkg.sv
package rltco_pkg;
    typedef enum logic [1:0] {
        RLTCO_RELOAD = 2'b00,
        RLTCO_CAPTURE = 2'b01,
        RLTCO_BAUD = 2'b10
    } rltco_mode_t;
endpackage

//--- verilog/rltco_top.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rltco_cfg.svh"
// Contract
// RQ1 - count is two cascaded bytes
// RQ2 - source is clock/12 or pin edges
// RQ3 - count only while run is set
// RQ4 - capture, reload and baud modes
// RQ5 - up/down enable takes direction from pin
// RQ6 - up overflow at FFFF sets flag
// RQ7 - up overflow loads reload pair
// RQ8 - down underflow when count equals reload
// RQ9 - underflow sets flag, loads FFFF
// RQ10 - external flag toggles, no interrupt
// RQ11 - clock-out counts at half clock
// RQ12 - clock-out reloads at each overflow
// RQ13 - clock-out overflows raise no interrupt
// RQ14 - pin clock is clk/(4*(65536-reload))
// RQ15 - software orders clock-out setup
// RQ16 - baud and clock-out share reload
// RQ17 - flag set only if serial selects clear
// RQ18 - serial select forces reload mode
// RQ19 - trigger edge sets external flag; the code sets it only while both serial selects are clear and up/down is off
// RQ20 - output enable turns pin into output
// RQ21 - capture copies count into reload
// RQ22 - pin synchronised, falling edge counts
module rltco_top #(
    parameter int OSC_DIV = `RLTCO_OSC_DIV
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic count_clock_pin_i,
    output logic count_clock_pin_o,
    output logic count_clock_pin_oe_o,
    input wire logic direction_trigger_input_i,
    output logic irq_o,
    output logic baud_tick_o
);

// ----------------------------------------
// register state
// ----------------------------------------
logic [7:0] ctrl_q, rdata_q;
logic [1:0] mode_q;
logic [7:0] count_low_byte_q, count_high_byte_q;
logic [7:0] reload_low_byte_q, reload_high_byte_q;
logic baud_q, clk_out_q;

function automatic logic wr_hit(
    input logic we,
    input logic [2:0] a,
    input logic [2:0] ofs
);
    wr_hit = we && (a == ofs);
endfunction

logic wr_ctrl, wr_mode, wr_cntl, wr_cnth, wr_rell, wr_relh;
assign wr_ctrl = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_CTRL);
assign wr_mode = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_MODE);
assign wr_cntl = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_CNTL);
assign wr_cnth = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_CNTH);
assign wr_rell = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_RELL);
assign wr_relh = wr_hit(reg_wr_i, reg_addr_i, `RLTCO_OFS_RELH);

logic overflow_flag, external_flag, serial_sel, external_trigger_enable;
logic run_control, counter_not_timer_select, capture_not_reload_select;
logic clock_output_enable, up_down_enable;
assign overflow_flag = ctrl_q[`RLTCO_B_OVF];
assign external_flag = ctrl_q[`RLTCO_B_EXF];
assign serial_sel = ctrl_q[`RLTCO_B_RXS] | ctrl_q[`RLTCO_B_TXS];
assign external_trigger_enable = ctrl_q[`RLTCO_B_EXEN];
assign run_control = ctrl_q[`RLTCO_B_RUN];
assign counter_not_timer_select = ctrl_q[`RLTCO_B_CNT];
assign capture_not_reload_select = ctrl_q[`RLTCO_B_CAP];
assign clock_output_enable = mode_q[`RLTCO_B_OE];
assign up_down_enable = mode_q[`RLTCO_B_UDEN];

logic [15:0] cnt, reload;
assign cnt = {count_high_byte_q, count_low_byte_q};
assign reload = {reload_high_byte_q, reload_low_byte_q};

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
logic pin_s1_q, pin_s2_q, pin_s3_q, dir_s1_q, dir_s2_q, dir_s3_q;
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        {pin_s3_q, pin_s2_q, pin_s1_q} <= 3'h7;
        {dir_s3_q, dir_s2_q, dir_s1_q} <= 3'h7;
    end else begin
        {pin_s3_q, pin_s2_q, pin_s1_q} <= {pin_s2_q, pin_s1_q,
            count_clock_pin_i};
        {dir_s3_q, dir_s2_q, dir_s1_q} <= {dir_s2_q, dir_s1_q,
            direction_trigger_input_i};
    end
end

logic pin_fall, dir_fall;
assign pin_fall = pin_s3_q && !pin_s2_q; // RQ22
assign dir_fall = dir_s3_q && !dir_s2_q;

// ----------------------------------------
// prescalers
// ----------------------------------------
logic [3:0] div_q;
logic half_q, div_tick;
assign div_tick = (div_q == 4'(OSC_DIV - 1));
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        div_q <= 4'h0;
        half_q <= 1'b0;
    end else begin
        div_q <= div_tick ? 4'h0 : div_q + 4'h1;
        half_q <= !half_q;
    end
end

// ----------------------------------------
// mode and count events
// ----------------------------------------
rltco_pkg::rltco_mode_t mode;
always_comb begin
    if (serial_sel) begin
        mode = rltco_pkg::RLTCO_BAUD; // RQ18
    end else if (capture_not_reload_select) begin
        mode = rltco_pkg::RLTCO_CAPTURE; // RQ4
    end else begin
        mode = rltco_pkg::RLTCO_RELOAD;
    end
end

logic fast_src, src_ev, tick;
// in timer mode, clock-out and baud run from the half-rate clock, else clock/12
assign fast_src = clock_output_enable || serial_sel;
always_comb begin
    if (counter_not_timer_select) begin
        src_ev = pin_fall; // RQ2
    end else if (fast_src) begin
        src_ev = half_q; // RQ11
    end else begin
        src_ev = div_tick; // RQ2
    end
end
assign tick = run_control && src_ev; // RQ3

logic updn, down, ovf, trig;
assign updn = up_down_enable && (mode == rltco_pkg::RLTCO_RELOAD);
assign down = updn && !dir_s2_q; // RQ5
always_comb begin
    if (down) begin
        ovf = tick && (cnt == reload); // RQ8
    end else begin
        ovf = tick && (cnt == `RLTCO_WORD_TOP); // RQ6
    end
end
// in up/down mode the trigger pin is the direction, not a trigger
assign trig = external_trigger_enable && !serial_sel && !updn
    && dir_fall;

// ----------------------------------------
// count registers
// ----------------------------------------
logic [15:0] cnt_d;
always_comb begin
    cnt_d = cnt;
    if (ovf) begin
        case (mode)
            rltco_pkg::RLTCO_CAPTURE: cnt_d = `RLTCO_WORD_RST;
            rltco_pkg::RLTCO_RELOAD: begin
                cnt_d = down ? `RLTCO_WORD_TOP : reload; // RQ7 RQ9
            end
            rltco_pkg::RLTCO_BAUD: cnt_d = reload; // RQ12 RQ16
            default: cnt_d = reload;
        endcase
    end else if (tick) begin
        cnt_d = down ? cnt - 16'h0001 : cnt + 16'h0001; // RQ1
    end
    if (trig && mode == rltco_pkg::RLTCO_RELOAD) begin
        cnt_d = reload;
    end
end

// software writes win over counting
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        count_low_byte_q <= 8'h00;
        count_high_byte_q <= 8'h00;
    end else begin
        count_low_byte_q <= wr_cntl ? reg_wdata_i : cnt_d[7:0];
        count_high_byte_q <= wr_cnth ? reg_wdata_i : cnt_d[15:8];
    end
end

// ----------------------------------------
// reload / capture registers
// ----------------------------------------
logic cap_ev;
assign cap_ev = trig && (mode == rltco_pkg::RLTCO_CAPTURE);
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        reload_low_byte_q <= 8'h00;
        reload_high_byte_q <= 8'h00;
    end else begin
        if (wr_rell) begin
            reload_low_byte_q <= reg_wdata_i;
        end else if (cap_ev) begin
            reload_low_byte_q <= count_low_byte_q; // RQ21
        end
        if (wr_relh) begin
            reload_high_byte_q <= reg_wdata_i;
        end else if (cap_ev) begin
            reload_high_byte_q <= count_high_byte_q; // RQ21
        end
    end
end

// ----------------------------------------
// control and mode registers
// ----------------------------------------
logic ovf_set, exf_set, exf_tgl, exf_base, tf_base;
assign ovf_set = ovf && !serial_sel && !clock_output_enable; // RQ17 RQ13
assign exf_set = trig; // RQ19
assign exf_tgl = ovf && updn; // RQ10
assign exf_base = wr_ctrl ? reg_wdata_i[`RLTCO_B_EXF] : external_flag;
assign tf_base = wr_ctrl ? reg_wdata_i[`RLTCO_B_OVF] : overflow_flag;

// hardware set wins over a software clear in the same cycle
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_q <= `RLTCO_CTRL_RST;
    end else begin
        if (wr_ctrl) begin
            ctrl_q[5:0] <= reg_wdata_i[5:0];
        end
        ctrl_q[`RLTCO_B_OVF] <= tf_base || ovf_set; // RQ6 RQ17
        ctrl_q[`RLTCO_B_EXF] <= exf_set || (exf_base ^ exf_tgl);
    end
end

always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        mode_q <= `RLTCO_MODE_RST;
    end else if (wr_mode) begin
        mode_q <= reg_wdata_i[1:0];
    end
end

// ----------------------------------------
// clock output and serial tick
// ----------------------------------------
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        clk_out_q <= 1'b0;
        baud_q <= 1'b0;
    end else begin
        // one toggle per overflow gives half the overflow rate
        if (ovf && clock_output_enable) begin
            clk_out_q <= !clk_out_q; // RQ14
        end
        baud_q <= ovf && serial_sel; // RQ16
    end
end

assign count_clock_pin_o = clk_out_q;
assign count_clock_pin_oe_o = clock_output_enable; // RQ20
assign baud_tick_o = baud_q;
// external flag does not interrupt in up/down mode
assign irq_o = overflow_flag || (external_flag && !up_down_enable);

// ----------------------------------------
// read port
// ----------------------------------------
always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `RLTCO_OFS_CTRL: rdata_q <= ctrl_q;
            `RLTCO_OFS_MODE: rdata_q <= {6'h00, mode_q};
            `RLTCO_OFS_CNTL: rdata_q <= count_low_byte_q;
            `RLTCO_OFS_CNTH: rdata_q <= count_high_byte_q;
            `RLTCO_OFS_RELL: rdata_q <= reload_low_byte_q;
            `RLTCO_OFS_RELH: rdata_q <= reload_high_byte_q;
            default: rdata_q <= 8'h00;
        endcase
    end else begin
        rdata_q <= 8'h00;
    end
end
assign reg_rdata_o = rdata_q;

// ----------------------------------------
// assertions
// ----------------------------------------
default clocking cb @(posedge ref_clk_i);
endclocking
default disable iff (!arst_n_i);

logic no_cnt_wr;
assign no_cnt_wr = !wr_cntl && !wr_cnth;
sequence s_half_tick;
    tick ##1 !tick;
endsequence
property p_cascade;
    (tick && !ovf && !down && !trig && no_cnt_wr)
        |=> cnt == $past(cnt) + 16'h0001;
endproperty
a_cascade: assert property (p_cascade) // RQ1
    else $error("count did not step up");
property p_stop;
    (!run_control && !trig && no_cnt_wr) |=> $stable(cnt);
endproperty
a_stop: assert property (p_stop) // RQ3
    else $error("count moved while stopped");
property p_up_reload;
    (ovf && !down && mode == rltco_pkg::RLTCO_RELOAD && no_cnt_wr
        && !trig) |=> cnt == $past(reload);
endproperty
a_up_reload: assert property (p_up_reload) // RQ7
    else $error("overflow did not reload");
property p_down_top;
    (ovf && down && no_cnt_wr) |=> cnt == 16'hFFFF;
endproperty
a_down_top: assert property (p_down_top) // RQ9
    else $error("underflow did not load top");
property p_flag_set;
    (tick && !down && cnt == 16'hFFFF && !serial_sel
        && !clock_output_enable) |=> overflow_flag && irq_o;
endproperty
a_flag_set: assert property (p_flag_set) // RQ17
    else $error("overflow flag not set");
property p_no_clkout_irq;
    (!overflow_flag && clock_output_enable && !wr_ctrl)
        |=> !overflow_flag;
endproperty
a_no_clkout_irq: assert property (p_no_clkout_irq) // RQ13
    else $error("clock-out overflow set flag");
property p_exf_toggle;
    (ovf && updn && !trig && !wr_ctrl)
        |=> external_flag != $past(external_flag);
endproperty
a_exf_toggle: assert property (p_exf_toggle) // RQ10
    else $error("external flag did not toggle");
property p_capture;
    (cap_ev && !wr_rell && !wr_relh) |=> reload == $past(cnt);
endproperty
a_capture: assert property (p_capture) // RQ21
    else $error("capture did not copy count");
property p_half_rate;
    (run_control && !counter_not_timer_select
        && clock_output_enable && tick) |-> s_half_tick;
endproperty
a_half_rate: assert property (p_half_rate) // RQ11
    else $error("clock-out ticks too often");
property p_pin_toggle;
    (ovf && clock_output_enable)
        |=> count_clock_pin_o != $past(count_clock_pin_o);
endproperty
a_pin_toggle: assert property (p_pin_toggle) // RQ14
    else $error("clock pin did not toggle");

endmodule
`default_nettype wire
